//--- rtl/mdt_consts.svh
// constants for the multimode delay timer: rates, register map, fields, reset values
`ifndef MDT_CONSTS_SVH
`define MDT_CONSTS_SVH
`define MDT_CLK_HZ 100000000
`define MDT_TICK_MS 100
`define MDT_TICK_CYC (`MDT_CLK_HZ / 1000 * `MDT_TICK_MS)
`define MDT_DB_US 1000
`define MDT_DB_CYC (`MDT_CLK_HZ / 1000000 * `MDT_DB_US)
`define MDT_NUM_IN 3
`define MDT_CNT_W 13
`define MDT_CNT_ONE 13'h0001
`define MDT_ADDR_CTRL 12'h000
`define MDT_ADDR_STAT 12'h004
`define MDT_ADDR_ELAP 12'h008
`define MDT_F_MODE 2:0
`define MDT_F_RANGE 4:3
`define MDT_F_FINE 8:5
`define MDT_F_RUN 9
`define MDT_S_OUT 0
`define MDT_S_TIMING 1
`define MDT_S_DONE 2
`define MDT_S_PINS 5:3
`define MDT_E_CNT 12:0
`define MDT_RST_MODE 3'h0
`define MDT_RST_RANGE 2'h0
`define MDT_RST_FINE 4'ha
`define MDT_RST_RUN 1'h1
`define MDT_FINE_MIN 4'h1
`define MDT_FINE_MAX 4'ha
`define MDT_MULT_R0 10'h001
`define MDT_MULT_R1 10'h00a
`define MDT_MULT_R2 10'h03c
`define MDT_MULT_R3 10'h258
`endif

//--- rtl/mdt_pkg.sv
// types shared by the multimode delay timer
package mdt_pkg;
  typedef enum logic [2:0] {
    MD_ON_DELAY,
    MD_OFF_DELAY,
    MD_INTEGRATE,
    MD_ONE_SHOT,
    MD_PULSE_OFF
  } mdt_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIMING,
    ST_DONE
  } mdt_state_t;
  typedef struct packed {
    logic run;
    logic [3:0] fine;
    logic [1:0] range;
    logic [2:0] mode;
  } mdt_cfg_t;
  typedef struct packed {
    logic start;
    logic clr;
    logic gate;
  } mdt_pins_t;
endpackage

//--- rtl/mdt_debounce.sv
// two-flop synchroniser and contact debouncer for one input line
`timescale 1ns/1ns
`default_nettype none
`include "mdt_consts.svh"
module mdt_debounce #(
  parameter int STABLE_CYC = `MDT_DB_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  localparam int CW = $clog2(STABLE_CYC + 1);
  logic meta_ff;
  logic sync_ff;
  logic dout_ff;
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  // new level taken only after it stood stable for the full window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      dout_ff <= 1'b0;
    end else if (sync_ff == dout_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CW'(STABLE_CYC - 1)) begin
      cnt_ff <= '0;
      dout_ff <= sync_ff;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  assign dout = dout_ff;
endmodule // mdt_debounce
`default_nettype wire

//--- rtl/mdt_prescale.sv
// base tick divider: one-cycle enable pulse every DIV enabled cycles
`timescale 1ns/1ns
`default_nettype none
`include "mdt_consts.svh"
module mdt_prescale #(
  parameter int DIV = `MDT_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic en,
  output logic tick
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] div_ff;

  // pauses with en so gated intervals add up exactly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else if (clr) begin
      div_ff <= '0;
    end else if (en) begin
      if (div_ff == CW'(DIV - 1)) begin
        div_ff <= '0;
      end else begin
        div_ff <= div_ff + CW'(1);
      end
    end
  end

  assign tick = en && !clr && (div_ff == CW'(DIV - 1));
endmodule // mdt_prescale
`default_nettype wire

//--- rtl/mdt_timer.sv
// multimode delay timer top: apb registers, input conditioning, timing core
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "mdt_consts.svh"
module mdt_timer
  import mdt_pkg::*;
#(
  parameter int TICK_CYC = `MDT_TICK_CYC,
  parameter int DB_CYC = `MDT_DB_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic START_IN,
  input wire logic EXT_RESET_IN,
  input wire logic GATE_IN,
  output logic LOAD_OUT
);
  logic [`MDT_NUM_IN-1:0] raw_v;
  logic [`MDT_NUM_IN-1:0] clean_v;
  mdt_pins_t pins;
  mdt_cfg_t cfg_ff;
  mdt_mode_t mode;
  mdt_state_t state_ff;
  mdt_state_t nxt_state;
  logic [`MDT_CNT_W-1:0] cnt_ff;
  logic [`MDT_CNT_W-1:0] nxt_cnt;
  logic [`MDT_CNT_W-1:0] tgt;
  logic out_ff;
  logic nxt_out;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_data;
  logic rd_hit;
  logic acc;
  logic wr_go;
  logic cfg_wr;
  logic restart_ff;
  logic restart;
  logic start_q_ff;
  logic start_rise;
  logic tick;
  logic cnt_en;
  logic cnt_clr;
  logic at_end;
  logic is_level;
  logic [3:0] fine_c;
  logic [9:0] mult;
  logic [13:0] prod;

  // input conditioning, one debouncer per contact line
  assign raw_v = {START_IN, EXT_RESET_IN, GATE_IN};
  genvar gi;
  generate
    for (gi = 0; gi < `MDT_NUM_IN; gi++) begin : g_in
      mdt_debounce #(
        .STABLE_CYC(DB_CYC)
      ) u_db (
        .clk(CLK),
        .rst_n(RESET_N),
        .din(raw_v[gi]),
        .dout(clean_v[gi])
      );
    end
  endgenerate
  assign pins = mdt_pins_t'(clean_v);

  // apb slave: one wait state, answer registered
  assign acc = PSEL && PENABLE;
  assign wr_go = acc && pready_ff && PWRITE;
  assign cfg_wr = wr_go && (PADDR == `MDT_ADDR_CTRL);

  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    case (PADDR)
      `MDT_ADDR_CTRL: begin
        rd_data[`MDT_F_MODE] = cfg_ff.mode;
        rd_data[`MDT_F_RANGE] = cfg_ff.range;
        rd_data[`MDT_F_FINE] = cfg_ff.fine;
        rd_data[`MDT_F_RUN] = cfg_ff.run;
      end
      `MDT_ADDR_STAT: begin
        rd_data[`MDT_S_OUT] = out_ff;
        rd_data[`MDT_S_TIMING] = (state_ff == ST_TIMING);
        rd_data[`MDT_S_DONE] = (state_ff == ST_DONE);
        rd_data[`MDT_S_PINS] = clean_v;
      end
      `MDT_ADDR_ELAP: begin
        rd_data[`MDT_E_CNT] = cnt_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= acc && !pready_ff;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (acc && !pready_ff) begin
      prdata_ff <= PWRITE ? 32'h0 : rd_data;
      pslverr_ff <= !rd_hit || (PWRITE && (PADDR != `MDT_ADDR_CTRL));
    end
  end

  // configuration; a write restarts timing as a power cycle would
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cfg_ff.mode <= `MDT_RST_MODE;
      cfg_ff.range <= `MDT_RST_RANGE;
      cfg_ff.fine <= `MDT_RST_FINE;
      cfg_ff.run <= `MDT_RST_RUN;
    end else if (cfg_wr) begin
      cfg_ff.mode <= PWDATA[`MDT_F_MODE];
      cfg_ff.range <= PWDATA[`MDT_F_RANGE];
      cfg_ff.fine <= PWDATA[`MDT_F_FINE];
      cfg_ff.run <= PWDATA[`MDT_F_RUN];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= cfg_wr;
    end
  end
  assign restart = restart_ff || !cfg_ff.run;

  // set time in base ticks: fine step times range multiplier (1, 10, 60 or 600)
  always_comb begin
    fine_c = cfg_ff.fine;
    if (fine_c < `MDT_FINE_MIN) begin
      fine_c = `MDT_FINE_MIN;
    end
    if (fine_c > `MDT_FINE_MAX) begin
      fine_c = `MDT_FINE_MAX;
    end
    case (cfg_ff.range)
      2'h0: mult = `MDT_MULT_R0;
      2'h1: mult = `MDT_MULT_R1;
      2'h2: mult = `MDT_MULT_R2;
      default: mult = `MDT_MULT_R3;
    endcase
    prod = {10'h0, fine_c} * {4'h0, mult};
    tgt = prod[`MDT_CNT_W-1:0];
  end

  assign mode = mdt_mode_t'(cfg_ff.mode);
  assign is_level = !((mode == MD_ONE_SHOT) || (mode == MD_PULSE_OFF));
  assign at_end = ({1'b0, cnt_ff} + 14'h1) >= {1'b0, tgt};

  // start edge for the pulse modes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      start_q_ff <= 1'b0;
    end else begin
      start_q_ff <= pins.start;
    end
  end
  assign start_rise = pins.start && !start_q_ff;

  mdt_prescale #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk(CLK),
    .rst_n(RESET_N),
    .clr(cnt_clr),
    .en(cnt_en),
    .tick(tick)
  );

  // timing core
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    cnt_en = 1'b0;
    cnt_clr = 1'b0;
    if (restart) begin
      nxt_state = is_level ? ST_TIMING : ST_IDLE;
      nxt_cnt = '0;
      nxt_out = 1'b0;
      cnt_clr = 1'b1;
    end else begin
      case (mode)
        MD_ONE_SHOT: begin
          if (start_rise) begin
            nxt_state = ST_TIMING;
            nxt_cnt = '0;
            nxt_out = 1'b1;
            cnt_clr = 1'b1;
          end else if ((state_ff == ST_TIMING) && pins.clr && !pins.start) begin
            nxt_state = ST_IDLE;
            nxt_cnt = '0;
            nxt_out = 1'b0;
            cnt_clr = 1'b1;
          end else if (state_ff == ST_TIMING) begin
            cnt_en = 1'b1;
          end
        end
        MD_PULSE_OFF: begin
          if (start_rise) begin
            nxt_state = ST_TIMING;
            nxt_cnt = '0;
            nxt_out = 1'b1;
            cnt_clr = 1'b1;
          end else if ((state_ff == ST_TIMING) && pins.clr) begin
            nxt_cnt = '0;
            cnt_clr = 1'b1;
          end else if (state_ff == ST_TIMING) begin
            cnt_en = 1'b1;
          end
        end
        default: begin
          if (pins.clr) begin
            nxt_state = ST_TIMING;
            nxt_cnt = '0;
            nxt_out = 1'b0;
            cnt_clr = 1'b1;
          end else if (state_ff == ST_TIMING) begin
            cnt_en = (mode != MD_INTEGRATE) || pins.gate;
          end
        end
      endcase
      if (cnt_en && tick) begin
        if (at_end) begin
          nxt_cnt = tgt;
          if (is_level) begin
            nxt_state = ST_DONE;
            nxt_out = 1'b1;
          end else begin
            nxt_state = ST_IDLE;
            nxt_out = 1'b0;
          end
        end else begin
          nxt_cnt = cnt_ff + `MDT_CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= ST_TIMING;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign LOAD_OUT = out_ff;
  assign PREADY = pready_ff;
  assign PRDATA = prdata_ff;
  assign PSLVERR = pslverr_ff;

  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_level_expire_out: assert property (
    (is_level && !restart && !pins.clr && (state_ff == ST_TIMING) && cnt_en && tick && at_end)
    |=> (out_ff && (state_ff == ST_DONE) && (cnt_ff == $past(tgt)))
  ) else $error("level mode did not assert output at set time");

  a_ext_reset_clear: assert property (
    (is_level && !restart && pins.clr) |=> (!out_ff && (cnt_ff == '0))
  ) else $error("external reset did not clear level timer");

  a_off_release_runs: assert property (
    (is_level && pins.clr && !restart) ##1 (!pins.clr && !restart && (mode != MD_INTEGRATE))
    |-> (cnt_en && (state_ff == ST_TIMING))
  ) else $error("timing did not start on reset release");

  a_gate_pause_hold: assert property (
    ((mode == MD_INTEGRATE) && !pins.gate && !pins.clr && !restart)
    |=> $stable(cnt_ff) [*2] or (cnt_ff == $past(cnt_ff))
  ) else $error("elapsed time moved while gate was low");

  a_integ_done_cause: assert property (
    ((mode == MD_INTEGRATE) && !restart && $rose(out_ff))
    |-> ($past(pins.gate) && $past(tick) && ($past(cnt_ff) + `MDT_CNT_ONE >= $past(tgt)))
  ) else $error("integrating output rose without full gated time");

  a_oneshot_start_out: assert property (
    ((mode == MD_ONE_SHOT) && start_rise && !restart)
    |=> (out_ff && (state_ff == ST_TIMING) && (cnt_ff == '0))
  ) else $error("one-shot start did not assert output");

  a_oneshot_reset_stop: assert property (
    ((mode == MD_ONE_SHOT) && (state_ff == ST_TIMING) && pins.clr && !pins.start && !restart)
    |=> (!out_ff && (state_ff == ST_IDLE))
  ) else $error("one-shot reset did not stop timing");

  a_pulse_suspend_hold: assert property (
    ((mode == MD_PULSE_OFF) && (state_ff == ST_TIMING) && pins.clr && !start_rise && !restart)
    |=> (out_ff && (cnt_ff == '0))
  ) else $error("pulse off-delay reset did not suspend timing");

  a_pulse_start_held: assert property (
    ((mode == MD_PULSE_OFF) && start_rise && pins.clr && !restart) |=> out_ff [*2]
    or (out_ff ##1 !pins.clr)
  ) else $error("start with reset held did not assert output");

  a_pulse_expire_drop: assert property (
    ((mode == MD_PULSE_OFF) && $fell(out_ff) && !$past(restart))
    |-> ($past(tick) && !$past(pins.clr) && ($past(cnt_ff) + `MDT_CNT_ONE >= $past(tgt)))
  ) else $error("pulse output dropped before set time");

  a_target_nonzero: assert property (
    (tgt >= {9'h0, `MDT_FINE_MIN}) && (tgt <= {3'h0, `MDT_FINE_MAX} * {3'h0, `MDT_MULT_R3})
  ) else $error("set time out of range");

  c_oneshot_done: cover property (
    (mode == MD_ONE_SHOT) && $fell(out_ff) && !$past(restart)
  );
  c_integ_done: cover property (
    (mode == MD_INTEGRATE) && $rose(out_ff)
  );
  c_pulse_suspend: cover property (
    (mode == MD_PULSE_OFF) && out_ff && pins.clr ##1 !pins.clr
  );
endmodule // mdt_timer
`default_nettype wire

//--- verif/mdt_contacts.sv
// contact input model: start, reset and gate pins with brief bounce
`timescale 1ns/1ns
`default_nettype none
module mdt_contacts
  import mdt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire mdt_pins_t want,
  output logic [2:0] pins
);
  mdt_pins_t last_ff;
  mdt_pins_t chg_ff;
  logic [1:0] bnc_ff;
  // a changed line falls back for one cycle, shorter than the debounce span
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_ff <= '0;
      chg_ff <= '0;
      bnc_ff <= 2'h0;
    end else begin
      last_ff <= want;
      if (want != last_ff) begin
        chg_ff <= want ^ last_ff;
        bnc_ff <= 2'h3;
      end else if (bnc_ff != 2'h0) begin
        bnc_ff <= bnc_ff - 2'h1;
      end
    end
  end
  // every contact, the reset one too, follows its request apart from the one bounce cycle
  assign pins = (rst_n && bnc_ff == 2'h2) ? want ^ chg_ff : want;
endmodule // mdt_contacts
`default_nettype wire

//--- verif/multimode_delay_timer_tb_top.sv
// self-checking bench for the multimode delay timer
`timescale 1ns/1ns
`default_nettype none
`include "mdt_consts.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module multimode_delay_timer_tb_top
  import mdt_pkg::*;
;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic LOAD_OUT;
  mdt_pins_t want = 3'h1;
  logic [2:0] pins;
  int checks = 0;
  int fail_count = 0;
  logic [66:0] q[$];
  logic [31:0] rs = 32'h53b3;
  logic [12:0] mult [4] = '{13'h1, 13'ha, 13'h3c, 13'h258};
  always #5 CLK = ~CLK;
  mdt_contacts mdt_contacts_i (.clk(CLK), .rst_n(RESET_N), .want(want), .pins(pins));
  mdt_timer #(.TICK_CYC(10), .DB_CYC(4)) mdt_timer_i (.CLK(CLK), .RESET_N(RESET_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .START_IN(pins[2]),
    .EXT_RESET_IN(pins[1]), .GATE_IN(pins[0]), .LOAD_OUT(LOAD_OUT));
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task w(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
    input logic [32:0] m, input logic l);
    @(posedge CLK);
    q.push_back({l, m, e});
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // waits as long as the slave takes; only the watchdog ends a hang
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // the oldest note is compared with whatever the slave answers
  always @(posedge CLK) begin
    logic [66:0] e;
    if (PREADY === 1'b1) begin
      e = q.size() ? q.pop_front() : '1;
      `CHK("apb", e[32:0], {PSLVERR, PRDATA} & e[65:33])
      if (e[66]) `CHK("load_out", e[0], LOAD_OUT)
    end
  end
  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m}, 1'b0);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 32'h0}, {1'b1, 32'h0}, 1'b0);
  endtask
  task out(input logic b);
    // status bit and the load pin itself are both held against b
    apb(1'b0, `MDT_ADDR_STAT, 32'h0, {32'h0, b}, {1'b1, 32'h1}, 1'b1);
  endtask
  task ctl(input logic [2:0] md, input logic [3:0] f, input logic [1:0] r);
    wr(`MDT_ADDR_CTRL, {22'h0, 1'b1, f, r, md}, 1'b0);
  endtask
  task poff(input logic pre);
    want.clr <= pre;
    w(10);
    want.start <= 1'b1;
    w(15);
    out(1'b1);
    want.clr <= 1'b1;
    w(60);
    out(1'b1);
    want.clr <= 1'b0;
    w(15);
    out(1'b1);
    w(40);
    out(1'b0);
    want.start <= 1'b0;
    w(10);
  endtask
  task stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    w(20000);
    fail_count++;
    stop_test();
  end
  initial begin
    w(4);
    RESET_N <= 1'b1;
    rd(`MDT_ADDR_CTRL, 32'h340, 32'h3ff);
    out(1'b0);
    w(100);
    rd(`MDT_ADDR_STAT, 32'h5, 32'h5);
    for (int r = 0; r < 4; r++) begin
      ctl(3'h0, 4'h1, r[1:0]);
      w(int'(mult[r]) * 10 - 8);
      out(1'b0);
      w(20);
      out(1'b1);
      rd(`MDT_ADDR_ELAP, {19'h0, mult[r]}, 32'h1fff);
    end
    apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0}, '1, 1'b0);
    void'(rnd());
    wr({2'h1, rs[7:0], 2'h0}, rnd(), 1'b1);
    wr(`MDT_ADDR_STAT, rnd(), 1'b1);
    rd(`MDT_ADDR_CTRL, 32'h238, 32'h3ff);
    want.clr <= 1'b1;
    w(20);
    out(1'b0);
    rd(`MDT_ADDR_ELAP, 32'h0, 32'h1fff);
    ctl(3'h1, 4'h3, 2'h0);
    w(60);
    out(1'b0);
    want.clr <= 1'b0;
    w(15);
    out(1'b0);
    w(40);
    out(1'b1);
    want.gate <= 1'b0;
    w(10);
    ctl(3'h2, 4'h3, 2'h0);
    w(60);
    out(1'b0);
    want.gate <= 1'b1;
    w(20);
    want.gate <= 1'b0;
    w(50);
    out(1'b0);
    want.gate <= 1'b1;
    w(25);
    out(1'b1);
    ctl(3'h3, 4'h5, 2'h0);
    want.start <= 1'b1;
    w(15);
    out(1'b1);
    want.start <= 1'b0;
    w(60);
    out(1'b0);
    want.start <= 1'b1;
    w(12);
    want.start <= 1'b0;
    w(5);
    want.clr <= 1'b1;
    w(15);
    out(1'b0);
    want.clr <= 1'b0;
    w(10);
    want.start <= 1'b1;
    w(1);
    want.start <= 1'b0;
    w(20);
    out(1'b0);
    ctl(3'h4, 4'h3, 2'h0);
    poff(1'b0);
    poff(1'b1);
    // spare mode code runs as on-delay; fine setting above ten is clamped to ten
    ctl(3'h7, 4'hf, 2'h0);
    w(90);
    out(1'b0);
    w(30);
    out(1'b1);
    rd(`MDT_ADDR_ELAP, 32'ha, 32'h1fff);
    stop_test();
  end
endmodule // multimode_delay_timer_tb_top
`default_nettype wire
